// ### sim/adcst_analog_model.sv
/*
 * Analog side model: gain amplifier and converter front end. Measures
 * how long each phase lasts, in clock cycles.
 * Assumes the controls are registered on the rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none

module adcst_analog_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Controls from the block
    input  wire logic        sample_on,
    input  wire logic        amp_sample,
    input  wire logic        amp_hold,
    input  wire logic        convert_on,
    // Measured lengths, in clock cycles, and amplifier output level
    output var  logic [15:0] win_len,
    output var  logic [15:0] amp_len,
    output var  logic [15:0] conv_len,
    output var  logic        amp_level
);
    logic [15:0] w_run, a_run, c_run;  // Running phase counts
    logic        in_level;             // Input toggles so a freeze shows

    // Count each phase and latch its length when it ends
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {w_run, a_run, c_run} <= 48'h0;
            {win_len, amp_len, conv_len} <= 48'h0;
            {in_level, amp_level} <= 2'h0;
        end else begin
            w_run <= sample_on ? w_run + 16'h1 : 16'h0;
            a_run <= amp_sample ? a_run + 16'h1 : 16'h0;
            c_run <= convert_on ? c_run + 16'h1 : 16'h0;
            if (!sample_on && w_run != 16'h0) win_len <= w_run;
            if (!amp_sample && a_run != 16'h0) amp_len <= a_run;
            if (!convert_on && c_run != 16'h0) conv_len <= c_run;
            in_level <= ~in_level;
            // Amplifier tracks its input except while held
            if (!amp_hold) amp_level <= in_level;
        end
    end
endmodule // adcst_analog_model

`default_nettype wire

// ### sim/adcst_timing_sva.sv
/*
 * Checker for the sample timing controller: APB answer timing, bias
 * output and order of the analog phases.
 * Assumes it is bound to adcst_timing and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module adcst_timing_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Analog controls
    input wire logic        sample_on,
    input wire logic        amp_hold,
    input wire logic        amp_sample,
    input wire logic [2:0]  amp_bias,
    input wire logic        convert_on,
    input wire logic        conv_done
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [2:0] bias_q;  // Bias field as last written
    wire        wr_amp = psel && penable && pready && pwrite && !pslverr
                         && paddr == 12'h010;

    // Track writes to the amplifier register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bias_q <= 3'h1;
        end else if (wr_amp) begin
            bias_q <= pwdata[7:5];
        end
    end

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("No answer after setup");
    chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("Answer outside access phase");
    chk_err_data: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("Refused read returned data");
    chk_bias_write: assert property (wr_amp |=> ##[0:1] amp_bias == bias_q)
        else $error("Bias output not the written field");
    chk_hold_only: assert property (amp_hold |-> amp_sample)
        else $error("Amplifier hold outside output sampling");
    chk_hold_amp: assert property (amp_sample |-> amp_hold)
        else $error("Amplifier not held");
    chk_phase_excl: assert property (sample_on |-> !convert_on)
        else $error("Window overlaps conversion");
    chk_conv_min: assert property ($rose(convert_on) |-> convert_on[*8])
        else $error("Conversion phase too short");
    chk_done_pulse: assert property (conv_done |=> !conv_done)
        else $error("Done longer than one cycle");
    chk_win_conv: assert property ($fell(sample_on) |-> ##[0:1] convert_on)
        else $error("Window end not followed by conversion");
endmodule // adcst_timing_sva

bind adcst_timing adcst_timing_sva u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_on(sample_on),
    .amp_hold(amp_hold), .amp_sample(amp_sample), .amp_bias(amp_bias),
    .convert_on(convert_on), .conv_done(conv_done));

`default_nettype wire

// ### sim/testbench.sv
/*
 * Bench for the sample timing controller: table rows, then hand cases.
 * Assumes a 10 MHz clock and the checker bound to the block.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    // Clock, reset and APB
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    // Analog side
    logic        sample_on, amp_hold, amp_sample, convert_on, conv_done;
    logic [2:0]  amp_bias;
    logic [15:0] win_len, amp_len, conv_len;
    int          num_errors, n_checks, cyc, t1, t2, t3, t4;

    // Case: amplifier, window, divider, expected window/amp/conv cycles
    typedef struct packed {
        logic amp; logic [7:0] win; logic [3:0] sel;
        logic [15:0] w; logic [15:0] a; logic [15:0] c;
    } adcst_row_t;
    adcst_row_t rows [0:4] = '{
        '{1'b0, 8'h00, 4'h0, 16'h0001, 16'h0000, 16'h001e},
        '{1'b0, 8'h03, 4'h1, 16'h000e, 16'h0000, 16'h003c},
        '{1'b1, 8'h02, 4'h0, 16'h0006, 16'h0004, 16'h001e},
        '{1'b1, 8'h05, 4'h2, 16'h0024, 16'h000c, 16'h005a},
        '{1'b0, 8'hff, 4'h0, 16'h01ff, 16'h0000, 16'h001e}};

    adcst_timing DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_on(sample_on),
        .amp_hold(amp_hold), .amp_sample(amp_sample), .amp_bias(amp_bias),
        .convert_on(convert_on), .conv_done(conv_done));
    adcst_analog_model u_analog (
        .pclk(pclk), .presetn(presetn), .sample_on(sample_on),
        .amp_sample(amp_sample), .amp_hold(amp_hold),
        .convert_on(convert_on), .win_len(win_len), .amp_len(amp_len),
        .conv_len(conv_len), .amp_level());

    // Clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            $display("Error timeout expected done seen hang");
            print_verdict;
        end
    end

    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic check(input string s, input logic [31:0] x,
                         input logic [31:0] y);
        n_checks++;
        if (y !== x) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", s, x, y);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input string s);
        apb(1'b0, a, 32'h0);
        check(s, x, q);
    endtask
    // Start one conversion and time it from the start write to done
    task automatic convert(input logic amp, output int t);
        longint t0;
        wr(12'h000, {29'h0, 1'b1, amp, 1'b1});
        t0 = $time;
        while (conv_done !== 1'b1) @(posedge pclk);
        t = int'(($time - t0) / 100);
        repeat (3) @(posedge pclk);
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        {psel, penable, pwrite, presetn} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(12'h008, 32'h1);
        for (int i = 0; i < 5; i++) begin
            wr(12'h004, {28'h0, rows[i].sel});
            wr(12'h00c, {24'h0, rows[i].win});
            wr(12'h000, {30'h0, rows[i].amp, 1'b1});
            convert(rows[i].amp, t1);
            check("window", {16'h0, rows[i].w}, {16'h0, win_len});
            check("convert", {16'h0, rows[i].c}, {16'h0, conv_len});
            if (rows[i].amp) check("amp", {16'h0, rows[i].a}, {16'h0, amp_len});
            wr(12'h000, 32'h0);
            $display("Row %0d done", i);
        end
        // Change only the sample field; bias must survive
        apb(1'b0, 12'h010, 32'h0);
        wr(12'h010, (q & 32'hffff_fff0) | 32'he);
        rd(12'h010, 32'h2e, "amp reg");
        wr(12'h010, 32'hce);
        wr(12'h004, 32'h0);
        check("bias", 32'h6, {29'h0, amp_bias});
        wr(12'h00c, 32'h0);
        wr(12'h000, 32'h3);
        convert(1'b1, t1);
        check("amp 15", 32'h1e, {16'h0, amp_len});
        wr(12'h000, 32'h0);
        $display("Amplifier test done");
        // Init delay scales with tick and is skipped once done
        wr(12'h000, 32'h1);
        convert(1'b0, t1);
        wr(12'h000, 32'h0);
        wr(12'h008, 32'h2);
        wr(12'h000, 32'h1);
        convert(1'b0, t2);
        check("tick delay", 32'd60, 32'(t2 - t1));
        wr(12'h000, 32'h0);
        wr(12'h00c, 32'h100);
        wr(12'h000, 32'h1);
        convert(1'b0, t3);
        convert(1'b0, t4);
        check("skip init", 32'd120, 32'(t3 - t4));
        wr(12'h000, 32'h0);
        $display("Init test done");
        // Unmapped address is refused
        apb(1'b0, 12'h018, 32'h0);
        check("err flag", 32'h1, {31'h0, e});
        check("err data", 32'h0, q);
        $display("Refusal test done");
        // Second reset restores register defaults
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h010, 32'h21, "amp reset");
        rd(12'h008, 32'h0a, "tick reset");
        $display("Reset test done");
        print_verdict;
    end
endmodule // testbench

`default_nettype wire

// ### src/adcst_clkdiv.v
/*
 * Converter clock divider: makes one-cycle half-period strobes of the
 * converter clock from the peripheral clock.
 * Assumes the select input is stable while enabled.
 */
`timescale 1ns/100ps
`default_nettype none

module adcst_clkdiv (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // Control
    input  wire        run,      // Divider runs while high
    input  wire [3:0]  sel,      // Division select
    // Strobes
    output reg         half,     // Pulse each half converter period
    output reg         rise      // Pulse at each converter clock rise
);

    // -----------------------------------------------------------------
    // Division table
    // -----------------------------------------------------------------
    reg  [6:0] half_len;         // Peripheral cycles per half period
    reg  [6:0] cnt;              // Half period counter
    reg        phase;            // Converter clock level
    wire       wrap;             // Last cycle of a half period

    // Division ratios 2,4,...; half length is ratio over two
    always @* begin
        case (sel)
            4'h0:    half_len = 7'd1;
            4'h1:    half_len = 7'd2;
            4'h2:    half_len = 7'd3;
            4'h3:    half_len = 7'd4;
            4'h4:    half_len = 7'd5;
            4'h5:    half_len = 7'd6;
            4'h6:    half_len = 7'd8;
            4'h7:    half_len = 7'd10;
            4'h8:    half_len = 7'd12;
            4'h9:    half_len = 7'd14;
            4'ha:    half_len = 7'd16;
            4'hb:    half_len = 7'd20;
            default: half_len = 7'd32;
        endcase
    end

    // -----------------------------------------------------------------
    // Counter
    // -----------------------------------------------------------------
    assign wrap = (cnt + 7'd1 >= half_len);

    // Strobes are not registered: a start-up cycle would stretch a phase
    always @* begin
        half = run & wrap;
        rise = run & wrap & ~phase;
    end

    // Restart on stop so each conversion begins on a clean phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt   <= 7'h00;
            phase <= 1'b0;
        end else if (!run) begin
            cnt   <= 7'h00;
            phase <= 1'b0;
        end else if (wrap) begin
            cnt   <= 7'h00;
            phase <= ~phase;
        end else begin
            cnt   <= cnt + 7'd1;
        end
    end

endmodule // adcst_clkdiv

`default_nettype wire

// ### src/adcst_consts.vh
/*
 * Constants for the converter sample timing controller: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from design files under src/.
 */
`ifndef ADCST_CONSTS_VH
`define ADCST_CONSTS_VH

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define ADCST_OFS_CTRL      12'h000
`define ADCST_OFS_DIV       12'h004
`define ADCST_OFS_REFT      12'h008
`define ADCST_OFS_SWIN      12'h00c
`define ADCST_OFS_AMP       12'h010
`define ADCST_OFS_STAT      12'h014

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define ADCST_CTRL_EN       0
`define ADCST_CTRL_AMPEN    1
`define ADCST_CTRL_START    2
`define ADCST_SWIN_SKIP_REINIT_BIT   8
`define ADCST_AMP_BIAS_LSB  5
`define ADCST_AMP_SDUR_LSB  0

// ---------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------
`define ADCST_AMP_RESET     8'h21
`define ADCST_TICK_RESET    8'h0a

// ---------------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------------
`define ADCST_INIT_US       8'd60
`define ADCST_CONV_CYC      5'd15
`define ADCST_AMP_SDUR_MAX  5'd16

`endif

// ### src/adcst_timing.v
/*
 * Sample timing controller for a successive-approximation converter with
 * an optional gain amplifier. APB slave for configuration and status.
 * Assumes one peripheral clock and analog logic driven from its outputs.
 */
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

`include "adcst_consts.vh"

// Function
// - Sampling window up to 256 converter cycles
// - Amplifier off: window is setting plus half
// - Amplifier on: window is setting plus one
// - Converter clock divided by select field
// - Software gives microsecond tick; delays use it
// - Amplifier holds only while its output sampled
// - Conversion: init plus setting plus 15.5
// - Skip-reinit bit: initialise once after enable
// - Amplifier output sampled for selected cycles
// - Amplifier control resets nonzero; fields preserved
// - Amplifier bias select field for power
module adcst_timing (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Analog controls
    output reg         sample_on,     // Input sampling switch closed
    output reg         amp_hold,      // Gain amplifier in hold
    output reg         amp_sample,    // Converter samples amplifier output
    output reg  [2:0]  amp_bias,      // Amplifier bias select
    output reg         convert_on,    // Conversion phase active
    output reg         conv_done      // One-cycle end of conversion
);

    // -----------------------------------------------------------------
    // States
    // -----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_INIT = 3'd1;
    localparam [2:0] ST_AMPS = 3'd2;
    localparam [2:0] ST_SAMP = 3'd3;
    localparam [2:0] ST_CONV = 3'd4;
    localparam [2:0] ST_DONE = 3'd5;

    // -----------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------
    // Software settings
    reg         enable;               // Converter enable
    reg         amp_en;               // Gain amplifier in use
    reg  [3:0]  clock_divider_select; // Division select
    reg  [7:0]  tick_count;           // Peripheral cycles per microsecond
    reg  [7:0]  sample_window_setting;// Sampling length setting
    reg         skip_reinit_bit;      // Low-latency option
    reg  [7:0]  amp_control_register; // Bias and output sample fields

    // Sequencer
    reg  [2:0]  state;                // Sequencer state
    reg  [8:0]  hcnt;                 // Half converter cycles in phase
    reg  [7:0]  tick;                 // Microsecond prescaler
    reg  [7:0]  us_cnt;               // Microseconds of initialisation
    reg         inited;               // Initialisation already done
    reg         start_req;            // Pending conversion start
    reg  [15:0] conv_total;           // Completed conversions

    // -----------------------------------------------------------------
    // Divider instance
    // -----------------------------------------------------------------
    wire        run_div;              // Divider runs in timed phases
    wire        half;                 // Half converter period strobe

    assign run_div = (state == ST_AMPS) || (state == ST_SAMP) ||
                     (state == ST_CONV);

    adcst_clkdiv u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run_div),
        .sel     (clock_divider_select),
        .half    (half),
        .rise    ()
    );

    // -----------------------------------------------------------------
    // APB decode
    // -----------------------------------------------------------------
    wire        acc;                  // Access phase
    wire        wr;                   // Write takes effect
    wire        mapped;               // Address hits a register
    wire [4:0]  amp_sdur;             // Amplifier output sample cycles
    wire [9:0]  samp_halves;          // Input window in half cycles

    assign acc    = psel & penable;
    assign wr     = acc & pwrite;
    assign mapped = (paddr == `ADCST_OFS_CTRL) ||
                    (paddr == `ADCST_OFS_DIV)  ||
                    (paddr == `ADCST_OFS_REFT) ||
                    (paddr == `ADCST_OFS_SWIN) ||
                    (paddr == `ADCST_OFS_AMP)  ||
                    (paddr == `ADCST_OFS_STAT);

    // Zero field value means one cycle, up to sixteen
    assign amp_sdur = {1'b0, amp_control_register[3:0]} + 5'd1;

    // Window in half cycles: 2*setting plus 1 or plus 2
    assign samp_halves = {1'b0, sample_window_setting, 1'b0} +
                         (amp_en ? 10'd2 : 10'd1);

    // Zero-wait-state slave: pready one cycle after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;

            if (psel & ~penable & pwrite)
                prdata <= 32'h0000_0000;
            else if (psel & ~penable) begin
                case (paddr)
                    `ADCST_OFS_CTRL:
                        prdata <= {30'h0, amp_en, enable};

                    `ADCST_OFS_DIV:
                        prdata <= {28'h0, clock_divider_select};

                    `ADCST_OFS_REFT:
                        prdata <= {24'h0, tick_count};

                    `ADCST_OFS_SWIN:
                        prdata <= {23'h0, skip_reinit_bit,
                                   sample_window_setting};

                    `ADCST_OFS_AMP:
                        prdata <= {24'h0, amp_control_register};

                    `ADCST_OFS_STAT:
                        prdata <= {conv_total, 8'h0, inited, start_req,
                                   3'h0, state};

                    default:
                        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    // Writes land in the access phase once pready has risen
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable                <= 1'b0;
            amp_en                <= 1'b0;
            clock_divider_select  <= 4'h0;
            tick_count            <= `ADCST_TICK_RESET;
            sample_window_setting <= 8'h00;
            skip_reinit_bit       <= 1'b0;
            amp_control_register  <= `ADCST_AMP_RESET;
        end else if (wr && pready) begin
            case (paddr)
                `ADCST_OFS_CTRL: begin
                    enable <= pwdata[`ADCST_CTRL_EN];
                    amp_en <= pwdata[`ADCST_CTRL_AMPEN];
                end

                `ADCST_OFS_DIV:  clock_divider_select <= pwdata[3:0];
                `ADCST_OFS_REFT: tick_count <= pwdata[7:0];

                `ADCST_OFS_SWIN: begin
                    sample_window_setting <= pwdata[7:0];
                    skip_reinit_bit <= pwdata[`ADCST_SWIN_SKIP_REINIT_BIT];
                end

                // Whole-register write; software keeps other fields
                `ADCST_OFS_AMP:  amp_control_register <= pwdata[7:0];

                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Start request
    // -----------------------------------------------------------------
    // Set wins over the sequencer's clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            start_req <= 1'b0;
        else if (wr && pready && paddr == `ADCST_OFS_CTRL &&
                 pwdata[`ADCST_CTRL_START] && enable)
            start_req <= 1'b1;
        else if (!enable || state == ST_DONE)
            start_req <= 1'b0;
    end

    // -----------------------------------------------------------------
    // Sequencer
    // -----------------------------------------------------------------
    // Half-cycle counting gives the 0.5 cycle figures exactly
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_IDLE;
            hcnt       <= 9'h000;
            tick       <= 8'h00;
            us_cnt     <= 8'h00;
            inited     <= 1'b0;
            conv_total <= 16'h0000;
            conv_done  <= 1'b0;
        end else begin
            conv_done <= 1'b0;

            if (!enable) begin
                state  <= ST_IDLE;
                inited <= 1'b0;      // Re-enable must initialise again
            end else begin
                case (state)
                    // Wait for start
                    ST_IDLE: begin
                        hcnt   <= 9'h000;
                        tick   <= 8'h00;
                        us_cnt <= 8'h00;
                        if (start_req) begin
                            // Low latency skips init after the first
                            if (skip_reinit_bit && inited)
                                state <= amp_en ? ST_AMPS : ST_SAMP;
                            else
                                state <= ST_INIT;
                        end
                    end

                    ST_INIT: begin
                        // Delay counted in microsecond ticks
                        if (tick + 8'd1 >= tick_count) begin
                            tick <= 8'h00;
                            if (us_cnt + 8'd1 >= `ADCST_INIT_US) begin
                                inited <= 1'b1;
                                state  <= amp_en ? ST_AMPS : ST_SAMP;
                            end else begin
                                us_cnt <= us_cnt + 8'd1;
                            end
                        end else begin
                            tick <= tick + 8'd1;
                        end
                    end

                    // Amplifier output phase
                    ST_AMPS: begin
                        if (half) begin
                            if (hcnt + 9'd1 >= {3'h0, amp_sdur, 1'b0}) begin
                                hcnt  <= 9'h000;
                                state <= ST_SAMP;
                            end else begin
                                hcnt <= hcnt + 9'd1;
                            end
                        end
                    end

                    // Input window open
                    ST_SAMP: begin
                        if (half) begin
                            if ({1'b0, hcnt} + 10'd1 >= samp_halves) begin
                                hcnt  <= 9'h000;
                                state <= ST_CONV;
                            end else begin
                                hcnt <= hcnt + 9'd1;
                            end
                        end
                    end

                    ST_CONV: begin
                        // Fixed 15 cycles plus the half from the window
                        if (half) begin
                            if (hcnt + 9'd1 >= {3'h0, `ADCST_CONV_CYC,
                                                1'b0}) begin
                                hcnt  <= 9'h000;
                                state <= ST_DONE;
                            end else begin
                                hcnt <= hcnt + 9'd1;
                            end
                        end
                    end

                    // Report and count
                    ST_DONE: begin
                        conv_done  <= 1'b1;
                        conv_total <= conv_total + 16'h0001;
                        state      <= ST_IDLE;
                    end

                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // Analog control outputs
    // -----------------------------------------------------------------
    // Registered from the state and the bias field so every output comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_on  <= 1'b0;
            amp_hold   <= 1'b0;
            amp_sample <= 1'b0;
            amp_bias   <= 3'h0;
            convert_on <= 1'b0;
        end else begin
            sample_on  <= (state == ST_SAMP);
            amp_hold   <= amp_en && (state == ST_AMPS);
            amp_sample <= (state == ST_AMPS);
            amp_bias   <= amp_control_register[7:5];
            convert_on <= (state == ST_CONV);
        end
    end

endmodule // adcst_timing

`default_nettype wire
